// ### design/rx_pkg.sv
/*
  Shared constants and types of the receive decoder and descrambler.
  Assumes one 40 MHz clock domain for all users.
*/
package rx_pkg;
  localparam int SAMPLE_W = 6;
  localparam int SUM_W = 10;
  localparam int MAG_W = 11;
  localparam int PHASE_W = 16;
  localparam int LEAD_SHIFT = 4;
  localparam int FIFO_DEPTH = 32;
  localparam int SCR_LEN = 7;
  localparam int SCR_TAP_A = 4;
  localparam int SCR_TAP_B = 7;
  localparam logic [2:0] FILL_BITS = 3'h7;
  localparam int TIMING_W = 8;
  localparam logic signed [TIMING_W-1:0] TIMING_LIMIT = 8'sh48;
  localparam int BARKER_LEN = 11;
  localparam logic [10:0] BARKER_CODE = 11'h5B8;
  localparam int MF_STAGES = 22;
  localparam int CCK_CHIPS = 8;
  localparam logic [6:0] CCK11_CAND = 7'h40;
  localparam logic [6:0] CCK55_CAND = 7'h04;
  localparam int LANES = 4;
  localparam int POL_BIT_A = 7;
  localparam int POL_BIT_B = 6;
  localparam logic [3:0] NBITS_DBPSK = 4'h1;
  localparam logic [3:0] NBITS_DQPSK = 4'h2;
  localparam logic [3:0] NBITS_CCK55 = 4'h4;
  localparam logic [3:0] NBITS_CCK11 = 4'h8;

  typedef enum logic [3:0] {
    MODE_DBPSK = 4'h1,
    MODE_DQPSK = 4'h2,
    MODE_CCK55 = 4'h4,
    MODE_CCK11 = 4'h8
  } rate_mode_type;

  typedef enum logic [2:0] {
    PICK_IDLE = 3'h1,
    PICK_SEARCH = 3'h2,
    PICK_EMIT = 3'h4
  } pick_state_type;

  typedef struct packed {
    logic signed [SAMPLE_W-1:0] i;
    logic signed [SAMPLE_W-1:0] q;
  } iq_type;

  typedef struct packed {
    logic signed [SUM_W-1:0] i;
    logic signed [SUM_W-1:0] q;
  } cplx_type;

  typedef struct packed {
    logic [3:0] nbits;
    logic [7:0] bits;
  } sym_word_type;
endpackage

// ### design/dsss_rx_decoder_descrambler.sv
/*
  Receive data recovery: derotation, carrier and timing tracking, Barker
  matched filter, DBPSK/DQPSK decoding, CCK picker, symbol FIFO, descrambler.
  Assumes samples, strobes and mode come from logic on the same clock.
*/
`timescale 1ns/100ps
`default_nettype none

// ----------------------------------------
// Symbol FIFO
// ----------------------------------------
module sym_fifo #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 32
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_reg, rd_reg;
  logic [AW:0] count_reg;
  logic push, pop;

  // Honest full and empty from the fill count
  assign in_ready = (count_reg != (AW+1)'(DEPTH));
  assign out_valid = (count_reg != '0);
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem[rd_reg];

  // Storage
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_reg] <= in_data;
    end
  end

  // Pointers and count
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wr_reg <= '0;
      rd_reg <= '0;
      count_reg <= '0;
    end else begin
      if (push) wr_reg <= AW'(wr_reg + 1'b1);
      if (pop) rd_reg <= AW'(rd_reg + 1'b1);
      count_reg <= (AW+1)'(count_reg + push - pop);
    end
  end
endmodule

// ----------------------------------------
// Decoder top
// ----------------------------------------
module dsss_rx_decoder_descrambler (
  input wire logic clk,
  input wire logic resetn,
  input wire logic sample_valid,
  input wire rx_pkg::iq_type sample,
  input wire rx_pkg::rate_mode_type rate_mode,
  input wire logic [7:0] io_polarity_register,
  input wire logic rx_active,
  input wire logic track_en,
  input wire logic sym_strobe,
  input wire logic header_last,
  input wire logic rx_bit_ready,
  output logic rx_bit_reg,
  output logic rx_bit_valid_reg,
  output logic overflow_reg,
  output logic signed [7:0] timing_offset_reg
);
  import rx_pkg::*;

  cplx_type mf_reg [MF_STAGES];
  cplx_type chip_reg [CCK_CHIPS];
  cplx_type batch_reg [CCK_CHIPS];
  cplx_type der, mf_sum, best_sum_reg, best_sum_next;
  cplx_type lane_sum [LANES];
  logic [MAG_W-1:0] lane_mag [LANES];
  logic [5:0] lane_cand [LANES];
  logic [MAG_W-1:0] best_mag_reg, best_mag_next;
  logic [5:0] best_cand_reg, best_cand_next, cand_reg;
  logic [PHASE_W-1:0] phase_reg, freq_reg;
  logic signed [SUM_W:0] err, err_reg;
  logic decim_reg, chip_valid, transition, prev_i_sign_reg, prev_q_sign_reg;
  logic mid_sign_reg, cck_run_reg, is11, rev, lr_fire, push_valid, fifo_in_ready;
  logic [2:0] chip_idx_reg, fill_reg;
  logic [1:0] last_quad_reg, ref_quad_reg, lr_quad, lr_diff, ck_quad, ck_diff;
  pick_state_type pick_reg;
  sym_word_type push_word, pop_word;
  logic fifo_out_valid, adv, out_bit;
  logic [7:0] ser_bits_reg;
  logic [3:0] ser_cnt_reg;
  logic [SCR_LEN-1:0] scr_reg;

  // Rotate by minus k quarter turns
  function automatic cplx_type rot_back(input cplx_type x, input logic [1:0] k);
    case (k)
      2'h0: rot_back = x;
      2'h1: rot_back = '{x.q, -x.i};
      2'h2: rot_back = '{-x.i, -x.q};
      default: rot_back = '{-x.q, x.i};
    endcase
  endfunction

  // Quadrant of a complex value
  function automatic logic [1:0] quad_of(input cplx_type x);
    logic [SUM_W-1:0] ai, aq;
    ai = x.i[SUM_W-1] ? SUM_W'(-x.i) : SUM_W'(x.i);
    aq = x.q[SUM_W-1] ? SUM_W'(-x.q) : SUM_W'(x.q);
    if (ai >= aq) quad_of = x.i[SUM_W-1] ? 2'h2 : 2'h0;
    else quad_of = x.q[SUM_W-1] ? 2'h3 : 2'h1;
  endfunction

  // Gray dibit of a phase step
  function automatic logic [1:0] dibit(input logic [1:0] d);
    dibit = {d[1], d[1] ^ d[0]};
  endfunction

  // Correlate the batch against one CCK code word with p1 removed
  function automatic cplx_type cck_corr(input logic [5:0] c, input logic top);
    logic [1:0] p2, p3, p4;
    logic [1:0] e [CCK_CHIPS];
    cplx_type acc, r;
    acc = '0;
    p2 = top ? c[5:4] : {c[0], 1'b1};
    p3 = top ? c[3:2] : 2'h0;
    p4 = top ? c[1:0] : {c[1], 1'b0};
    e[0] = 2'(p2 + p3 + p4);
    e[1] = 2'(p3 + p4);
    e[2] = 2'(p2 + p4);
    e[3] = 2'(p4 + 2'h2);
    e[4] = 2'(p2 + p3);
    e[5] = p3;
    e[6] = 2'(p2 + 2'h2);
    e[7] = 2'h0;
    for (int k = 0; k < CCK_CHIPS; k++) begin
      r = rot_back(batch_reg[k], e[k]);
      acc.i = SUM_W'(acc.i + r.i);
      acc.q = SUM_W'(acc.q + r.q);
    end
    cck_corr = acc;
  endfunction

  assign is11 = (rate_mode == MODE_CCK11);
  assign rev = io_polarity_register[POL_BIT_A] | io_polarity_register[POL_BIT_B];

  // ----------------------------------------
  // Carrier derotation and tracking
  // ----------------------------------------
  // derotate before decimation
  assign der = rot_back('{SUM_W'(sample.i), SUM_W'(sample.q)}, phase_reg[PHASE_W-1 -: 2]);
  assign chip_valid = sample_valid && !decim_reg;
  assign transition = chip_valid &&
    ((der.i[SUM_W-1] != prev_i_sign_reg) || (der.q[SUM_W-1] != prev_q_sign_reg));
  // Four-phase Costas detector
  assign err = (der.i[SUM_W-1] ? -(SUM_W+1)'(der.q) : (SUM_W+1)'(der.q)) -
               (der.q[SUM_W-1] ? -(SUM_W+1)'(der.i) : (SUM_W+1)'(der.i));

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) decim_reg <= 1'b0;
    else if (header_last) decim_reg <= 1'b0;
    else if (sample_valid) decim_reg <= !decim_reg;
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      err_reg <= '0;
      freq_reg <= '0;
      phase_reg <= '0;
    end else if (!track_en) begin
      err_reg <= '0;
      freq_reg <= '0;
      phase_reg <= '0;
    end else if (chip_valid) begin
      if (transition) err_reg <= err;
      freq_reg <= PHASE_W'(freq_reg + PHASE_W'(err_reg));
      phase_reg <= PHASE_W'(phase_reg + freq_reg + (PHASE_W'(err_reg) <<< LEAD_SHIFT));
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      prev_i_sign_reg <= 1'b0;
      prev_q_sign_reg <= 1'b0;
      mid_sign_reg <= 1'b0;
      timing_offset_reg <= '0;
    end else if (sample_valid) begin
      if (decim_reg) mid_sign_reg <= der.i[SUM_W-1];
      if (chip_valid) begin
        prev_i_sign_reg <= der.i[SUM_W-1];
        prev_q_sign_reg <= der.q[SUM_W-1];
        if (track_en && der.i[SUM_W-1] != prev_i_sign_reg) begin
          if (mid_sign_reg == prev_i_sign_reg && timing_offset_reg != -TIMING_LIMIT)
            timing_offset_reg <= TIMING_W'(timing_offset_reg - 1'b1);
          else if (mid_sign_reg != prev_i_sign_reg && timing_offset_reg != TIMING_LIMIT)
            timing_offset_reg <= TIMING_W'(timing_offset_reg + 1'b1);
        end
      end
    end
  end

  // ----------------------------------------
  // Low-rate path
  // ----------------------------------------
  // two samples per chip, alternate taps
  always_ff @(posedge clk) begin
    if (sample_valid) begin
      mf_reg[0] <= der;
      for (int k = 1; k < MF_STAGES; k++) mf_reg[k] <= mf_reg[k-1];
    end
  end

  always_comb begin
    mf_sum = '0;
    for (int k = 0; k < BARKER_LEN; k++) begin
      mf_sum.i = SUM_W'(BARKER_CODE[k] ? mf_sum.i + mf_reg[2*k].i : mf_sum.i - mf_reg[2*k].i);
      mf_sum.q = SUM_W'(BARKER_CODE[k] ? mf_sum.q + mf_reg[2*k].q : mf_sum.q - mf_reg[2*k].q);
    end
  end

  // symbol timing from the low-rate section
  assign lr_fire = sym_strobe && rx_active &&
    (rate_mode == MODE_DBPSK || rate_mode == MODE_DQPSK);
  assign lr_quad = quad_of(mf_sum);
  assign lr_diff = rev ? 2'(last_quad_reg - lr_quad) : 2'(lr_quad - last_quad_reg);

  // header phase becomes the CCK reference
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      last_quad_reg <= '0;
      ref_quad_reg <= '0;
      cck_run_reg <= 1'b0;
    end else begin
      if (lr_fire) last_quad_reg <= lr_quad;
      if (header_last) ref_quad_reg <= last_quad_reg;
      else if (pick_reg == PICK_EMIT) ref_quad_reg <= ck_quad;
      if (!rx_active) cck_run_reg <= 1'b0;
      else if (header_last && (rate_mode == MODE_CCK55 || is11)) cck_run_reg <= 1'b1;
    end
  end

  // ----------------------------------------
  // CCK batch correlator and picker
  // ----------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) chip_idx_reg <= '0;
    else if (header_last) chip_idx_reg <= '0;
    else if (chip_valid && cck_run_reg) chip_idx_reg <= 3'(chip_idx_reg + 1'b1);
  end

  // Chip gathering and batch hand-off
  always_ff @(posedge clk) begin
    if (chip_valid && cck_run_reg) chip_reg[chip_idx_reg] <= der;
    if (chip_valid && cck_run_reg && chip_idx_reg == 3'h7) begin
      for (int k = 0; k < CCK_CHIPS - 1; k++) batch_reg[k] <= chip_reg[k];
      batch_reg[CCK_CHIPS-1] <= der;
    end
  end

  for (genvar l = 0; l < LANES; l++) begin : g_lane
    assign lane_cand[l] = 6'(cand_reg + l);
    assign lane_sum[l] = cck_corr(lane_cand[l], is11);
    assign lane_mag[l] = MAG_W'(lane_sum[l].i[SUM_W-1] ? -lane_sum[l].i : lane_sum[l].i) +
                         MAG_W'(lane_sum[l].q[SUM_W-1] ? -lane_sum[l].q : lane_sum[l].q);
  end

  always_comb begin
    best_mag_next = best_mag_reg;
    best_cand_next = best_cand_reg;
    best_sum_next = best_sum_reg;
    for (int l = 0; l < LANES; l++) begin
      if (lane_mag[l] > best_mag_next) begin
        best_mag_next = lane_mag[l];
        best_cand_next = lane_cand[l];
        best_sum_next = lane_sum[l];
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pick_reg <= PICK_IDLE;
      cand_reg <= '0;
      best_mag_reg <= '0;
      best_cand_reg <= '0;
      best_sum_reg <= '0;
    end else begin
      unique case (pick_reg)
        PICK_IDLE: begin
          cand_reg <= '0;
          best_mag_reg <= '0;
          best_cand_reg <= '0;
          best_sum_reg <= '0;
          if (chip_valid && cck_run_reg && chip_idx_reg == 3'h7) pick_reg <= PICK_SEARCH;
        end
        PICK_SEARCH: begin
          cand_reg <= 6'(cand_reg + LANES);
          best_mag_reg <= best_mag_next;
          best_cand_reg <= best_cand_next;
          best_sum_reg <= best_sum_next;
          if (7'(cand_reg + LANES) == (is11 ? CCK11_CAND : CCK55_CAND)) pick_reg <= PICK_EMIT;
        end
        PICK_EMIT: pick_reg <= PICK_IDLE;
      endcase
    end
  end

  assign ck_quad = quad_of(best_sum_reg);
  assign ck_diff = rev ? 2'(ref_quad_reg - ck_quad) : 2'(ck_quad - ref_quad_reg);

  // ----------------------------------------
  // Symbol packing and FIFO
  // ----------------------------------------
  // first-in-time bit packed at the top
  always_comb begin
    push_word = '0;
    push_valid = lr_fire || (pick_reg == PICK_EMIT);
    if (pick_reg == PICK_EMIT) begin
      // six index bits plus two phase bits
      if (is11) push_word = '{NBITS_CCK11, {dibit(ck_diff), best_cand_reg}};
      // two index bits plus two phase bits
      else push_word = '{NBITS_CCK55, {dibit(ck_diff), best_cand_reg[1:0], 4'h0}};
    end else if (rate_mode == MODE_DQPSK) begin
      push_word = '{NBITS_DQPSK, {dibit(lr_diff), 6'h00}};
    end else begin
      push_word = '{NBITS_DBPSK, {lr_diff[1], 7'h00}};
    end
  end

  // Sticky loss flag while the frame lasts
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) overflow_reg <= 1'b0;
    else if (push_valid && !fifo_in_ready) overflow_reg <= 1'b1;
    else if (!rx_active) overflow_reg <= 1'b0;
  end

  sym_fifo #(.WIDTH($bits(sym_word_type)), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk(clk),
    .resetn(resetn),
    .in_valid(push_valid),
    .in_ready(fifo_in_ready),
    .in_data(push_word),
    .out_valid(fifo_out_valid),
    .out_ready(ser_cnt_reg == 4'h0),
    .out_data(pop_word)
  );

  // ----------------------------------------
  // Serializer and descrambler
  // ----------------------------------------
  assign adv = !rx_bit_valid_reg || rx_bit_ready;
  // incoming bit XOR taps four and seven
  assign out_bit = ser_bits_reg[7] ^ scr_reg[SCR_TAP_A-1] ^ scr_reg[SCR_TAP_B-1];

  // shift received bits into the register
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ser_bits_reg <= '0;
      ser_cnt_reg <= '0;
      scr_reg <= '0;
      fill_reg <= '0;
      rx_bit_reg <= 1'b0;
      rx_bit_valid_reg <= 1'b0;
    end else begin
      if (rx_bit_ready) rx_bit_valid_reg <= 1'b0;
      if (!rx_active) fill_reg <= '0;
      if (ser_cnt_reg == 4'h0) begin
        if (fifo_out_valid) begin
          ser_bits_reg <= pop_word.bits;
          ser_cnt_reg <= pop_word.nbits;
        end
      end else if (adv) begin
        ser_bits_reg <= {ser_bits_reg[6:0], 1'b0};
        ser_cnt_reg <= 4'(ser_cnt_reg - 1'b1);
        scr_reg <= {scr_reg[SCR_LEN-2:0], ser_bits_reg[7]};
        if (rx_active && fill_reg != FILL_BITS) fill_reg <= 3'(fill_reg + 1'b1);
        if (fill_reg == FILL_BITS) begin
          rx_bit_reg <= out_bit;
          rx_bit_valid_reg <= 1'b1;
        end
      end
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  timing_limit_a: assert property (@(posedge clk) disable iff (!resetn)
    timing_offset_reg <= TIMING_LIMIT && timing_offset_reg >= -TIMING_LIMIT)
    else $error("timing offset beyond limit");
  fill_gate_a: assert property (@(posedge clk) disable iff (!resetn)
    $rose(rx_bit_valid_reg) |-> $past(fill_reg) == FILL_BITS)
    else $error("output valid before register filled");
  descramble_xor_a: assert property (@(posedge clk) disable iff (!resetn)
    (adv && ser_cnt_reg != 4'h0 && fill_reg == FILL_BITS) |=>
    rx_bit_valid_reg && rx_bit_reg == $past(ser_bits_reg[7] ^ scr_reg[3] ^ scr_reg[6]))
    else $error("descrambled bit wrong");
  pll_idle_a: assert property (@(posedge clk) disable iff (!resetn)
    !track_en |=> phase_reg == '0 && freq_reg == '0)
    else $error("carrier loop active in acquisition");
  err_hold_a: assert property (@(posedge clk) disable iff (!resetn)
    (track_en && !transition) |=> $stable(err_reg))
    else $error("carrier error moved without transition");
  dibit_map_a: assert property (@(posedge clk) disable iff (!resetn)
    (lr_fire && rate_mode == MODE_DQPSK && lr_diff == 2'h3) |-> push_word.bits[7:6] == 2'h2)
    else $error("minus ninety not mapped to 10");
  rotation_rev_a: assert property (@(posedge clk) disable iff (!resetn)
    (lr_fire && rev) |-> lr_diff == 2'(last_quad_reg - lr_quad))
    else $error("rotation sense not reversed");
  ref_latch_a: assert property (@(posedge clk) disable iff (!resetn)
    header_last |=> ref_quad_reg == $past(last_quad_reg))
    else $error("header phase not latched");
  cck_width_a: assert property (@(posedge clk) disable iff (!resetn)
    (pick_reg == PICK_EMIT) |-> push_word.nbits == (is11 ? NBITS_CCK11 : NBITS_CCK55))
    else $error("CCK symbol width wrong");
  cck_search_a: assert property (@(posedge clk) disable iff (!resetn)
    (pick_reg == PICK_IDLE ##1 pick_reg == PICK_SEARCH && rate_mode == MODE_CCK55) |=>
    pick_reg == PICK_EMIT)
    else $error("lower CCK rate searched too long");
  dqpsk_push_c: cover property (@(posedge clk) disable iff (!resetn)
    lr_fire && rate_mode == MODE_DQPSK);
  cck_emit_c: cover property (@(posedge clk) disable iff (!resetn)
    pick_reg == PICK_EMIT && is11);
  timing_sat_c: cover property (@(posedge clk) disable iff (!resetn)
    timing_offset_reg == TIMING_LIMIT);
  fifo_full_c: cover property (@(posedge clk) disable iff (!resetn)
    push_valid && !fifo_in_ready);
endmodule
`default_nettype wire

// ### bench/proto_proc_model.sv
/*
  Protocol processor model: accepts descrambled bits with random stalls.
  Assumes the decoder holds each bit until it is taken.
*/
`timescale 1ns/100ps
`default_nettype none
module proto_proc_model (
  input wire logic clk,
  input wire logic resetn,
  input wire logic stall,
  input wire logic rx_bit_reg,
  input wire logic rx_bit_valid_reg,
  output var logic rx_bit_ready,
  output logic took,
  output var logic hold_err
);
  logic wait_reg;
  logic bit_reg;
  initial rx_bit_ready = 1'b0;
  assign took = rx_bit_valid_reg & rx_bit_ready;
  // Random ready just after each edge
  always @(posedge clk) begin
    #2 rx_bit_ready = !stall && ($urandom % 2 == 0);
  end
  // Flag a bit that changes or drops before it is taken
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wait_reg <= 1'b0;
      hold_err <= 1'b0;
    end else begin
      if (wait_reg && (!rx_bit_valid_reg || rx_bit_reg !== bit_reg))
        hold_err <= 1'b1;
      wait_reg <= rx_bit_valid_reg && !rx_bit_ready;
      bit_reg <= rx_bit_reg;
    end
  end
endmodule
`default_nettype wire

// ### bench/dsss_rx_decoder_descrambler_test.sv
/*
  Testbench of the receive decoder: PSK decoding, descrambling, FIFO, timing.
  Assumes the protocol processor model and the rx_pkg package.
*/
`timescale 1ns/100ps
`default_nettype none
module dsss_rx_decoder_descrambler_test;
  import rx_pkg::*;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic sample_valid = 1'b0;
  logic rx_active = 1'b0;
  logic track_en = 1'b0;
  logic sym_strobe = 1'b0;
  logic header_last = 1'b0;
  logic stall = 1'b0;
  iq_type sample = '0;
  rate_mode_type rate_mode = MODE_DBPSK;
  logic [7:0] io_polarity_register = 8'h00;
  logic rx_bit_ready, rx_bit_reg, rx_bit_valid_reg, overflow_reg, took, hold_err;
  logic signed [7:0] timing_offset_reg;
  int error_cnt = 0;
  int n_tests = 0;
  logic scr[$];
  logic got[$];

  dsss_rx_decoder_descrambler dsss_rx_decoder_descrambler_inst (
    .clk(clk), .resetn(resetn), .sample_valid(sample_valid), .sample(sample),
    .rate_mode(rate_mode), .io_polarity_register(io_polarity_register),
    .rx_active(rx_active), .track_en(track_en), .sym_strobe(sym_strobe),
    .header_last(header_last), .rx_bit_ready(rx_bit_ready), .rx_bit_reg(rx_bit_reg),
    .rx_bit_valid_reg(rx_bit_valid_reg), .overflow_reg(overflow_reg),
    .timing_offset_reg(timing_offset_reg));
  proto_proc_model proto_proc_model_inst (
    .clk(clk), .resetn(resetn), .stall(stall), .rx_bit_reg(rx_bit_reg),
    .rx_bit_valid_reg(rx_bit_valid_reg), .rx_bit_ready(rx_bit_ready),
    .took(took), .hold_err(hold_err));

  // Clock and bit capture
  always #12.5 clk = ~clk;
  always @(posedge clk) if (took) got.push_back(rx_bit_reg);

  task automatic check_bit(input string what, input logic exp, input logic seen);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %b seen %b", what, exp, seen);
    end
  endtask
  task automatic check_byte(input string what, input logic [7:0] exp, input logic [7:0] seen);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask
  task automatic do_reset;
    resetn = 1'b0;
    tick(2);
    resetn = 1'b1;
    got.delete();
    tick(1);
  endtask
  // On-axis point of quarter turn q, counterclockwise from plus I
  function automatic iq_type point(input logic [1:0] q);
    iq_type p;
    p.i = (q == 2'h0) ? 6'sh14 : (q == 2'h2) ? 6'sh2C : 6'sh00;
    p.q = (q == 2'h1) ? 6'sh14 : (q == 2'h3) ? 6'sh2C : 6'sh00;
    return p;
  endfunction
  task automatic send_sym(input logic [1:0] q);
    sample = point(q);
    repeat (24) begin
      sample_valid = 1'b1;
      tick(1);
      sample_valid = 1'b0;
      tick(1);
    end
    sym_strobe = 1'b1;
    tick(1);
    sym_strobe = 1'b0;
  endtask

  task automatic run_psk(input rate_mode_type m, input logic [7:0] pol);
    logic [1:0] q, prev, d;
    int w, n;
    w = (m == MODE_DQPSK) ? 2 : 1;
    do_reset();
    scr.delete();
    rate_mode = m;
    io_polarity_register = pol;
    rx_active = 1'b1;
    prev = 2'h0;
    for (int k = 0; k < 30; k++) begin
      q = 2'($urandom % 4);
      if (k >= 1 && k <= 4)
        q = prev + 2'(k - 1);
      send_sym(q);
      d = q - prev;
      if (pol[7] | pol[6])
        d = -d;
      scr.push_back(d[1]);
      if (w == 2)
        scr.push_back(d[1] ^ d[0]);
      prev = q;
    end
    n = 0;
    while (got.size() < scr.size() - 7 && n < 3000) begin
      tick(1);
      n++;
    end
    if (n == 3000) begin
      error_cnt++;
      give_verdict();
    end
    tick(20);
    check_byte("bit_count", 8'(scr.size() - 7), 8'(got.size()));
    for (int j = 7 + w; j < scr.size(); j++)
      check_bit("rx_bit", scr[j] ^ scr[j-4] ^ scr[j-7], got[j-7]);
    check_byte("timing_idle", 8'h00, timing_offset_reg);
    check_bit("bit_hold", 1'b0, hold_err);
    rx_active = 1'b0;
    $display("test psk mode %h polarity %h done", m, pol);
  endtask

  task automatic run_overflow;
    int n, idle;
    do_reset();
    rate_mode = MODE_DQPSK;
    rx_active = 1'b1;
    stall = 1'b1;
    send_sym(2'h0);
    sym_strobe = 1'b1;
    tick(48);
    sym_strobe = 1'b0;
    tick(2);
    check_bit("overflow_set", 1'b1, overflow_reg);
    stall = 1'b0;
    n = 0;
    idle = 0;
    while (idle < 30 && n < 4000) begin
      tick(1);
      n++;
      idle = rx_bit_valid_reg ? 0 : idle + 1;
    end
    if (n == 4000) begin
      error_cnt++;
      give_verdict();
    end
    check_bit("drained_bits", 1'b1, got.size() >= 57);
    check_bit("overflow_sticky", 1'b1, overflow_reg);
    rx_active = 1'b0;
    tick(2);
    check_bit("overflow_clear", 1'b0, overflow_reg);
    $display("test overflow done");
  endtask

  // CCK frame of twenty symbols, chips spaced so the picker keeps up
  task automatic run_cck(input rate_mode_type m, input int nb);
    do_reset();
    rate_mode = m;
    rx_active = 1'b1;
    sample = point(2'h0);
    header_last = 1'b1;
    tick(1);
    header_last = 1'b0;
    repeat (320) begin
      sample_valid = 1'b1;
      tick(1);
      sample_valid = 1'b0;
      tick(2);
    end
    tick(100);
    check_byte("cck_bits", 8'(20 * nb - 7), 8'(got.size()));
    check_bit("cck_hold", 1'b0, hold_err);
    rx_active = 1'b0;
    $display("test cck mode %h done", m);
  endtask

  task automatic run_timing;
    logic bad;
    logic signed [7:0] t;
    bad = 1'b0;
    do_reset();
    rate_mode = MODE_DBPSK;
    rx_active = 1'b1;
    track_en = 1'b1;
    header_last = 1'b1;
    tick(1);
    header_last = 1'b0;
    for (int k = 0; k < 640; k++) begin
      sample = (k % 4 == 1 || k % 4 == 2) ? {6'sh2C, 6'sh2C} : {6'sh14, 6'sh14};
      sample_valid = 1'b1;
      tick(1);
      sample_valid = 1'b0;
      tick(1);
      if (timing_offset_reg > 72 || timing_offset_reg < -72)
        bad = 1'b1;
    end
    t = timing_offset_reg;
    check_bit("timing_range", 1'b0, bad);
    check_byte("timing_sat", 8'h48, t < 0 ? -t : t);
    track_en = 1'b0;
    rx_active = 1'b0;
    $display("test timing done");
  endtask

  // Main sequence
  initial begin
    void'($urandom(33566));
    do_reset();
    check_bit("valid_reset", 1'b0, rx_bit_valid_reg);
    check_bit("overflow_reset", 1'b0, overflow_reg);
    for (int p = 0; p < 3; p++) begin
      run_psk(MODE_DBPSK, 8'h80 >> (p == 0 ? 8 : p - 1));
      run_psk(MODE_DQPSK, 8'h80 >> (p == 0 ? 8 : p - 1));
    end
    run_cck(MODE_CCK55, int'(NBITS_CCK55));
    run_cck(MODE_CCK11, int'(NBITS_CCK11));
    run_overflow();
    run_timing();
    give_verdict();
  end
endmodule
`default_nettype wire
